// ==== rtl/usmp_top.v ====
// strap capture, base address selection and modem pin handling for four serial ports
`timescale 1ns/1ps
`include "usmp_consts.vh"
module usmp_top #(
  parameter PORTS = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // strap levels sampled from the shared output pins
  input wire watchdog_fixed_interval_strap,
  input wire config_port_select_strap,
  input wire port1_primary_base_strap,
  input wire port1_alternate_base_strap,
  input wire port2_primary_base_strap,
  input wire port2_alternate_base_strap,
  input wire port3_base_strap,
  input wire port4_base_strap,
  input wire config_key_strap_low,
  input wire config_key_strap_high,
  // programmed settings
  input wire [7:0] wdt_prog_interval,
  input wire [4*12-1:0] prog_base,
  // resolved configuration
  output reg [7:0] config_port_addr,
  output reg [7:0] wdt_interval,
  output reg wdt_interval_fixed,
  output reg [4*12-1:0] port_base,
  output reg [1:0] config_key,
  output reg strap_phase,
  // uart core side, active high per port
  input wire [PORTS-1:0] core_rts,
  input wire [PORTS-1:0] core_dtr,
  input wire [PORTS-1:0] core_tx,
  output wire [PORTS-1:0] core_rx,
  output wire [PORTS-1:0] status_cts,
  output wire [PORTS-1:0] status_dsr,
  output wire [PORTS-1:0] status_dcd,
  output wire [PORTS-1:0] status_ri,
  // modem pins
  output reg [PORTS-1:0] request_to_send_n,
  output reg [PORTS-1:0] request_to_send_n_oe,
  output reg [PORTS-1:0] terminal_ready_n,
  output reg [PORTS-1:0] terminal_ready_n_oe,
  output reg [PORTS-1:0] serial_tx_out,
  output reg [PORTS-1:0] serial_tx_out_oe,
  input wire [PORTS-1:0] clear_to_send_n,
  input wire [PORTS-1:0] set_ready_n,
  input wire [PORTS-1:0] carrier_detect_n,
  input wire [PORTS-1:0] ring_indicator_n,
  input wire [PORTS-1:0] serial_rx_in
);
  // all strap pins in one vector
  wire [9:0] strap_raw = {config_key_strap_high, config_key_strap_low,
    port4_base_strap, port3_base_strap, port2_alternate_base_strap,
    port2_primary_base_strap, port1_alternate_base_strap,
    port1_primary_base_strap, config_port_select_strap,
    watchdog_fixed_interval_strap};
  wire [9:0] strap_sync;
  wire [5*PORTS-1:0] modem_sync;
  wire [PORTS-1:0] rts_n_next;
  wire [PORTS-1:0] dtr_n_next;
  wire [PORTS-1:0] tx_next;
  wire pins_driven;
  reg [9:0] strap_reg;
  reg [2:0] phase_reg;
  reg [2:0] phase_next;
  reg [1:0] settle_cnt_reg;
  reg [1:0] settle_cnt_next;
  reg [4*12-1:0] base_next;
  genvar gi;
  // pin release phases, one-hot
  localparam ST_CAPTURE = 3'b001;
  localparam ST_SETTLE = 3'b010;
  localparam ST_RUN = 3'b100;
  // straps must hold real pin data while reset is low, so this synchroniser is never cleared
  usmp_sync #(.WIDTH(10)) u_strap_sync (
    .ref_clk(ref_clk),
    .rst_n(1'b1),
    .din(strap_raw),
    .dout(strap_sync)
  );
  // modem pins are synchronised raw; no gate sits in front of the first flop
  // not cleared either: status keeps following the pins, which idle inactive
  usmp_sync #(.WIDTH(5*PORTS)) u_modem_sync (
    .ref_clk(ref_clk),
    .rst_n(1'b1),
    .din({clear_to_send_n, set_ready_n, carrier_detect_n, ring_indicator_n, serial_rx_in}),
    .dout(modem_sync)
  );
  // per port: modem control pins are active low, the core side is active high; serial data is not inverted
  generate
    for (gi = 0; gi < PORTS; gi = gi + 1) begin : g_port
      assign status_cts[gi] = ~modem_sync[4*PORTS+gi];
      assign status_dsr[gi] = ~modem_sync[3*PORTS+gi];
      assign status_dcd[gi] = ~modem_sync[2*PORTS+gi];
      assign status_ri[gi] = ~modem_sync[PORTS+gi];
      assign core_rx[gi] = modem_sync[gi];
      assign rts_n_next[gi] = ~core_rts[gi];
      assign dtr_n_next[gi] = ~core_dtr[gi];
      assign tx_next[gi] = core_tx[gi];
    end
  endgenerate
  // strap capture: tracks pins while reset is low, frozen afterwards
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      strap_reg <= strap_sync;
    end
  end
  // pins stay released during reset and a few cycles after, so the outside
  // strap resistors are not fought while the captured values settle
  always @* begin
    phase_next = phase_reg;
    settle_cnt_next = settle_cnt_reg;
    case (phase_reg)
      ST_CAPTURE: begin
        phase_next = ST_SETTLE;
        settle_cnt_next = 2'h0;
      end
      ST_SETTLE: begin
        if (settle_cnt_reg == `USMP_SETTLE_LAST) begin
          phase_next = ST_RUN;
        end else begin
          settle_cnt_next = settle_cnt_reg + 2'h1;
        end
      end
      ST_RUN: begin
        phase_next = ST_RUN;
      end
      default: begin
        phase_next = ST_CAPTURE;
        settle_cnt_next = 2'h0;
      end
    endcase
  end
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= ST_CAPTURE;
      settle_cnt_reg <= 2'h0;
      strap_phase <= 1'b1;
    end else begin
      phase_reg <= phase_next;
      settle_cnt_reg <= settle_cnt_next;
      strap_phase <= ~pins_driven;
    end
  end
  // drivers turn on one cycle after the run phase is entered
  assign pins_driven = phase_reg[2];
  always @* begin
    base_next = prog_base;
    if (strap_reg[3]) begin
      base_next[11:0] = `USMP_P1_ALT_BASE;
    end
    if (strap_reg[2]) begin
      base_next[11:0] = `USMP_P1_PRI_BASE;
    end
    if (strap_reg[5]) begin
      base_next[23:12] = `USMP_P2_ALT_BASE;
    end
    if (strap_reg[4]) begin
      base_next[23:12] = `USMP_P2_PRI_BASE;
    end
    if (strap_reg[6]) begin
      base_next[35:24] = `USMP_P3_BASE;
    end
    if (strap_reg[7]) begin
      base_next[47:36] = `USMP_P4_BASE;
    end
  end
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_port_addr <= `USMP_CFG_PORT_DEFAULT;
      wdt_interval <= 8'h00;
      wdt_interval_fixed <= 1'b0;
      port_base <= {48{1'b0}};
      config_key <= 2'h0;
    end else begin
      config_port_addr <= strap_reg[1] ? `USMP_CFG_PORT_ALT : `USMP_CFG_PORT_DEFAULT;
      wdt_interval_fixed <= strap_reg[0];
      wdt_interval <= strap_reg[0] ? `USMP_WDT_FIXED_SEC : wdt_prog_interval;
      port_base <= base_next;
      config_key <= strap_reg[9:8];
    end
  end
  // pin drivers: released during strap phase, idle high after reset
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      request_to_send_n <= {PORTS{1'b1}};
      terminal_ready_n <= {PORTS{1'b1}};
      serial_tx_out <= {PORTS{1'b1}};
      request_to_send_n_oe <= {PORTS{1'b0}};
      terminal_ready_n_oe <= {PORTS{1'b0}};
      serial_tx_out_oe <= {PORTS{1'b0}};
    end else begin
      request_to_send_n <= rts_n_next;
      terminal_ready_n <= dtr_n_next;
      serial_tx_out <= tx_next;
      request_to_send_n_oe <= {PORTS{pins_driven}};
      terminal_ready_n_oe <= {PORTS{pins_driven}};
      serial_tx_out_oe <= {PORTS{pins_driven}};
    end
  end
endmodule

// ==== rtl/usmp_consts.vh ====
// constants for the strap capture and modem pin block
// Notes on behaviour
// - watchdog strap high fixes interval at 10s
// - config strap selects port 0x4e or 0x2e
// - port1 primary strap forces base 0x3f8
// - port1 alternate strap forces base 0x3e0
// - port2 primary strap forces base 0x2f8
// - port2 alternate strap forces base 0x2e0
// - port3 strap forces base 0x3e8
// - port4 strap forces base 0x2e8
// - all straps low: base from register
// - request to send driven low when ready
// - terminal ready driven low when ready
// - clear to send reported as modem status
// - serial characters received on serial input
// - serial characters sent on serial output
`ifndef USMP_CONSTS_VH
`define USMP_CONSTS_VH
`define USMP_CFG_PORT_DEFAULT 8'h4e
`define USMP_CFG_PORT_ALT 8'h2e
`define USMP_P1_PRI_BASE 12'h3f8
`define USMP_P1_ALT_BASE 12'h3e0
`define USMP_P2_PRI_BASE 12'h2f8
`define USMP_P2_ALT_BASE 12'h2e0
`define USMP_P3_BASE 12'h3e8
`define USMP_P4_BASE 12'h2e8
`define USMP_WDT_FIXED_SEC 8'h0a
`define USMP_SYNC_STAGES 2
`define USMP_SETTLE_LAST 2'h1
`endif

// ==== rtl/usmp_sync.v ====
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module usmp_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // data
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end
  assign dout = sync_reg;
endmodule

// ==== testbench/usmp_top_properties.sv ====
// checker for usmp_top
`timescale 1ns/1ps
module usmp_props (
  input wire ref_clk,
  input wire rst_n,
  input wire [3:0] core_rts, core_tx, clear_to_send_n, status_cts,
  input wire [3:0] request_to_send_n, serial_tx_out,
  input wire [7:0] wdt_prog_interval, wdt_interval, config_port_addr,
  input wire wdt_interval_fixed,
  input wire strap_phase
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_run; $past(rst_n); endsequence
  sequence s_free; strap_phase ##[1:5] !strap_phase; endsequence
  property p_rts; s_run |-> request_to_send_n == ~$past(core_rts); endproperty
  property p_tx; s_run |-> serial_tx_out == $past(core_tx); endproperty
  property p_cts; $past(rst_n, 2) |-> status_cts == ~$past(clear_to_send_n, 2); endproperty
  property p_fix; wdt_interval_fixed |-> wdt_interval == 8'h0a; endproperty
  property p_prog; s_run ##0 !wdt_interval_fixed |-> wdt_interval == $past(wdt_prog_interval);
  endproperty
  property p_cfg; config_port_addr == 8'h4e || config_port_addr == 8'h2e; endproperty
  property p_hold; $past(rst_n, 2) |-> $stable(config_port_addr); endproperty
  property p_free; $rose(rst_n) |-> s_free; endproperty
  a_rts: assert property (p_rts) else $error("rts");
  a_tx: assert property (p_tx) else $error("tx");
  a_cts: assert property (p_cts) else $error("cts");
  a_fix: assert property (p_fix) else $error("fix");
  a_prog: assert property (p_prog) else $error("prog");
  a_cfg: assert property (p_cfg) else $error("cfg");
  a_hold: assert property (p_hold) else $error("hold");
  a_free: assert property (p_free) else $error("free");
endmodule
bind usmp_top usmp_props i_usmp_props (.*);

// ==== testbench/usmp_modem.sv ====
// modem model: active-low status lines, echoes serial data
`timescale 1ns/1ps
module usmp_modem (
  input wire ref_clk,
  input wire [3:0] m_cts, m_dsr, m_dcd, m_ri, serial_tx_out,
  output reg [3:0] clear_to_send_n = 4'hf, set_ready_n = 4'hf, carrier_detect_n = 4'hf,
  output reg [3:0] ring_indicator_n = 4'hf, serial_rx_in = 4'hf
);
  always @(negedge ref_clk) begin
    clear_to_send_n <= ~m_cts;
    set_ready_n <= ~m_dsr;
    carrier_detect_n <= ~m_dcd;
    ring_indicator_n <= ~m_ri;
    serial_rx_in <= serial_tx_out;
  end
endmodule

// ==== testbench/usmp_top_tb.sv ====
// testbench for usmp_top
`timescale 1ns/1ps
module usmp_top_tb;
  reg ref_clk = 1'b0, rst_n = 1'b0;
  reg [9:0] st = 10'h000;
  reg [7:0] wdt_prog_interval = 8'h37;
  reg [47:0] prog_base = 48'h123123123123;
  reg [3:0] core_rts = 4'h0, core_dtr = 4'h0, core_tx = 4'h0;
  reg [3:0] m_cts = 4'h0, m_dsr = 4'h0, m_dcd = 4'h0, m_ri = 4'h0;
  wire [7:0] config_port_addr, wdt_interval;
  wire [47:0] port_base;
  wire [1:0] config_key;
  wire [3:0] core_rx, status_cts, status_dsr, status_dcd, status_ri, serial_rx_in;
  wire [3:0] request_to_send_n, terminal_ready_n, serial_tx_out, clear_to_send_n;
  wire [3:0] set_ready_n, carrier_detect_n, ring_indicator_n;
  wire wdt_interval_fixed, strap_phase;
  wire [3:0] request_to_send_n_oe, terminal_ready_n_oe, serial_tx_out_oe;
  wire [12:0] drv = {strap_phase, request_to_send_n_oe, terminal_ready_n_oe, serial_tx_out_oe};
  integer fails = 0, total_checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  usmp_top i_usmp_top (.*, .watchdog_fixed_interval_strap(st[0]),
    .config_port_select_strap(st[1]), .port1_primary_base_strap(st[2]),
    .port1_alternate_base_strap(st[3]), .port2_primary_base_strap(st[4]),
    .port2_alternate_base_strap(st[5]), .port3_base_strap(st[6]), .port4_base_strap(st[7]),
    .config_key_strap_low(st[8]), .config_key_strap_high(st[9]));
  usmp_modem i_usmp_modem (.*);
  task chk(input string nm, input [63:0] seen, input [63:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task t_strap(input [9:0] s, input [15:0] cw, input [47:0] base);
    st = s;
    rst_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("rst", {drv, config_port_addr}, {13'h1000, 8'h4e});
    chk("rstb", port_base, 48'h0);
    rst_n = 1'b1;
    st = ~s;
    @(negedge ref_clk);
    chk("phs", drv, 13'h1000);
    repeat (3) @(negedge ref_clk);
    chk("drv", drv, 13'h0fff);
    repeat (2) @(negedge ref_clk);
    chk("cfg", {config_port_addr, wdt_interval, wdt_interval_fixed}, {cw, s[0]});
    chk("base", {config_key, port_base}, {s[9:8], base});
    $display("strap test done");
  endtask
  task t_modem(input [3:0] v);
    {core_rts, core_dtr, core_tx, wdt_prog_interval} = {v, ~v, v, v, ~v};
    {m_cts, m_dsr, m_dcd, m_ri} = {v, ~v, v, ~v};
    repeat (6) @(negedge ref_clk);
    chk("out", {request_to_send_n, terminal_ready_n}, {~v, v});
    chk("ser", {serial_tx_out, core_rx, wdt_interval}, {v, v, v, ~v});
    chk("sts", {status_cts, status_dsr}, {v, ~v});
    chk("sts", {status_dcd, status_ri}, {v, ~v});
    $display("modem test done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    t_strap(10'h000, 16'h4e37, 48'h123123123123);
    t_strap(10'h3ff, 16'h2e0a, 48'h2e83e82f83f8);
    t_strap(10'h02a, 16'h2e37, 48'h1231232e03e0);
    t_modem(4'h5);
    t_modem(4'ha);
    final_report;
  end
  initial begin
    #20000;
    fails = fails + 1;
    final_report;
  end
endmodule
